// >>> logic/hds_spi_slave.sv
// Serial register slave of the haptic driver: frames, registers, ready event.
// Assumes serial pins and the enable pin are asynchronous to clk and the
// serial clock runs at a small fraction of clk.
`default_nettype none

module hds_spi_slave
  import hds_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire hds_pkg::hds_serial_in_s serial_in,
  output logic miso,
  output logic miso_oe_n,
  // Device pins
  input wire logic enable_low_pin,
  output logic interrupt_request_line_n,
  // Live conditions from the analog side
  input wire hds_pkg::hds_condition_s conditions,
  // Control strobes and stream data to the engine
  output logic digital_reset_pulse,
  output logic play_pulse,
  output logic abort_stream_pulse,
  output logic stream_push,
  output logic [11:0] stream_data
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  hds_serial_in_s ser_meta;
  hds_serial_in_s ser_sync;
  logic sclk_prev;
  logic en_meta;
  logic en_sync;
  hds_condition_s cond_meta;
  hds_condition_s cond_sync;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ser_meta <= '{sclk: 1'b0, chip_select_low: 1'b1, mosi: 1'b0};
      ser_sync <= '{sclk: 1'b0, chip_select_low: 1'b1, mosi: 1'b0};
      sclk_prev <= 1'b0;
      en_meta <= 1'b1;
      en_sync <= 1'b1;
      cond_meta <= '0;
      cond_sync <= '0;
    end
    else
    begin
      ser_meta <= serial_in;
      ser_sync <= ser_meta;
      sclk_prev <= ser_sync.sclk;
      en_meta <= enable_low_pin;
      en_sync <= en_meta;
      cond_meta <= conditions;
      cond_sync <= cond_meta;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;

  assign sclk_rise = ser_sync.sclk & ~sclk_prev;
  assign sclk_fall = ~ser_sync.sclk & sclk_prev;
  assign selected = ~ser_sync.chip_select_low;

  // ----------------------------------------------------------------------
  // Register storage and read decode
  // ----------------------------------------------------------------------
  logic [15:0] event_flags;
  logic [15:0] event_mask;
  logic [1:0] playback;

  function automatic logic [15:0] read_reg(input logic [14:0] a,
                                           input hds_condition_s c,
                                           input logic [15:0] flags,
                                           input logic [15:0] mask,
                                           input logic [1:0] play);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      HDS_REG_LIVE_CONDITION_FLAGS: v = {9'h000, c};
      HDS_REG_PLAYBACK_TRIGGER: v = {14'h0000, play};
      HDS_REG_EVENT_FLAGS: v = flags;
      HDS_REG_EVENT_MASK: v = mask;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  hds_state_e state;
  logic [3:0] bit_cnt;
  logic [14:0] rx_shift;
  logic [15:0] tx_shift;
  logic [14:0] cur_addr;
  logic is_read;
  logic [15:0] word_in;
  logic word_done;
  logic read_load;
  logic [14:0] read_addr;
  logic wrap_event;
  logic write_now;

  assign word_in = {rx_shift, ser_sync.mosi};
  assign word_done = selected & sclk_rise & (bit_cnt == HDS_LAST_BIT);
  // Read header in head state, or next header of a read burst
  assign read_load = word_done
                     & ((state == HDS_ST_HEAD & word_in[15] == HDS_DIR_READ)
                        | (state == HDS_ST_DATA & is_read));
  assign read_addr = word_in[14:0];
  assign write_now = word_done & (state == HDS_ST_DATA) & ~is_read;

  always_comb
  begin
    wrap_event = 1'b0;
    if (word_done & state == HDS_ST_DATA)
    begin
      if (is_read)
        wrap_event = read_addr > HDS_ADDR_TOP;
      else if (cur_addr != HDS_REG_STREAM_WRITE_PORT)
        wrap_event = cur_addr > HDS_ADDR_TOP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst | ~selected)
    begin
      state <= HDS_ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 15'h0000;
      cur_addr <= 15'h0000;
      is_read <= 1'b0;
    end
    else
    begin
      if (state == HDS_ST_IDLE)
        state <= HDS_ST_HEAD;
      if (sclk_rise)
      begin
        rx_shift <= word_in[14:0];
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (word_done)
      begin
        unique case (state)
          HDS_ST_HEAD:
          begin
            is_read <= word_in[15] == HDS_DIR_READ;
            cur_addr <= read_addr;
            state <= HDS_ST_DATA;
          end
          HDS_ST_DATA:
          begin
            if (is_read)
              cur_addr <= read_addr;
            else if (cur_addr != HDS_REG_STREAM_WRITE_PORT)
              cur_addr <= cur_addr + 15'h0001;
          end
          default: state <= HDS_ST_IDLE;
        endcase
      end
    end
  end

  // Output shifter; sync lag eats part of the low half period of sclk
  always_ff @(posedge clk)
  begin
    if (rst | ~selected)
    begin
      tx_shift <= 16'h0000;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end
    else
    begin
      miso_oe_n <= 1'b0;
      if (read_load)
        tx_shift <= read_reg(read_addr, cond_sync, event_flags, event_mask,
                             playback);
      else if (sclk_fall)
      begin
        miso <= (state == HDS_ST_DATA & is_read) ? tx_shift[15] : 1'b0;
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      event_mask <= HDS_EVENT_MASK_RESET;
      playback <= HDS_PLAYBACK_RESET;
      digital_reset_pulse <= 1'b0;
      play_pulse <= 1'b0;
      abort_stream_pulse <= 1'b0;
      stream_push <= 1'b0;
      stream_data <= 12'h000;
    end
    else
    begin
      digital_reset_pulse <= write_now & cur_addr == HDS_REG_DIGITAL_RESET_REQUEST
                             & word_in[HDS_BIT_SOFT_RESET];
      play_pulse <= write_now & cur_addr == HDS_REG_PLAYBACK_TRIGGER
                    & word_in[HDS_BIT_PLAY];
      abort_stream_pulse <= write_now & cur_addr == HDS_REG_PLAYBACK_TRIGGER
                            & word_in[HDS_BIT_ABORT_STREAM];
      stream_push <= write_now & cur_addr == HDS_REG_STREAM_WRITE_PORT;
      if (write_now)
      begin
        if (cur_addr == HDS_REG_EVENT_MASK)
          event_mask <= word_in;
        if (cur_addr == HDS_REG_PLAYBACK_TRIGGER)
          playback <= word_in[1:0];
        if (cur_addr == HDS_REG_STREAM_WRITE_PORT)
          stream_data <= word_in[HDS_STREAM_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Ready timer after enable
  // ----------------------------------------------------------------------
  logic [HDS_READY_CNT_W-1:0] ready_cnt;
  logic ready_done;
  logic ready_event;

  assign ready_event = ~en_sync & ~ready_done
                       & ready_cnt == HDS_READY_CNT_W'(HDS_READY_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (rst | en_sync)
    begin
      ready_cnt <= '0;
      ready_done <= 1'b0;
    end
    else if (~ready_done)
    begin
      ready_cnt <= ready_cnt + 1'b1;
      ready_done <= ready_event;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags and interrupt line
  // ----------------------------------------------------------------------
  logic [15:0] flag_set;
  logic [15:0] flag_clr;

  always_comb
  begin
    flag_set = 16'h0000;
    flag_set[HDS_BIT_LINK_READY] = ready_event;
    flag_set[HDS_BIT_ADDRESS_WRAP] = wrap_event;
    // Clear on read; only bits captured into the shifter are dropped
    flag_clr = (read_load & read_addr == HDS_REG_EVENT_FLAGS) ? event_flags : 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      event_flags <= HDS_EVENT_FLAGS_RESET;
      interrupt_request_line_n <= 1'b1;
    end
    else
    begin
      event_flags <= (event_flags & ~flag_clr) | flag_set;
      interrupt_request_line_n <= ~|(event_flags & ~event_mask);
    end
  end

endmodule

`default_nettype wire

// >>> shared/hds_pkg.sv
// Constants and carrier types for the haptic driver serial register slave.
// Assumes a 10 MHz system clock and a mode 0 serial master far slower than it.
`default_nettype none

package hds_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int HDS_CLK_MHZ = 10;
  localparam int HDS_READY_DELAY_US = 320;
  localparam int HDS_READY_CYCLES = HDS_READY_DELAY_US * HDS_CLK_MHZ;
  localparam int HDS_READY_CNT_W = 12;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int HDS_WORD_BITS = 16;
  localparam logic [3:0] HDS_LAST_BIT = 4'hf;
  localparam logic HDS_DIR_READ = 1'b1;
  localparam logic [14:0] HDS_ADDR_TOP = 15'h3fff;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [14:0] HDS_REG_DIGITAL_RESET_REQUEST = 15'h0000;
  localparam logic [14:0] HDS_REG_LIVE_CONDITION_FLAGS = 15'h0001;
  localparam logic [14:0] HDS_REG_PLAYBACK_TRIGGER = 15'h0002;
  localparam logic [14:0] HDS_REG_EVENT_FLAGS = 15'h0006;
  localparam logic [14:0] HDS_REG_EVENT_MASK = 15'h0007;
  localparam logic [14:0] HDS_REG_STREAM_WRITE_PORT = 15'h000a;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int HDS_BIT_SOFT_RESET = 0;
  localparam int HDS_BIT_PLAY = 0;
  localparam int HDS_BIT_ABORT_STREAM = 1;
  localparam int HDS_BIT_LINK_READY = 14;
  localparam int HDS_BIT_ADDRESS_WRAP = 11;
  localparam int HDS_STREAM_W = 12;
  localparam logic [15:0] HDS_EVENT_MASK_RESET = 16'h0000;
  localparam logic [15:0] HDS_EVENT_FLAGS_RESET = 16'h0000;
  localparam logic [1:0] HDS_PLAYBACK_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic chip_select_low;
    logic mosi;
  } hds_serial_in_s;

  typedef struct packed {
    logic stream_almost_empty;
    logic stream_full;
    logic stream_empty;
    logic pump_ok;
    logic undervoltage;
    logic thermal_ok;
    logic bias_ok;
  } hds_condition_s;

  typedef enum logic [2:0] {
    HDS_ST_IDLE = 3'b001,
    HDS_ST_HEAD = 3'b010,
    HDS_ST_DATA = 3'b100
  } hds_state_e;

endpackage

`default_nettype wire

// >>> dv/hds_spi_slave_props.sv
// Pin-level checker for the serial register slave.
// Assumes a mode 0 master far slower than clk.
`default_nettype none

module hds_spi_slave_props
  import hds_pkg::*;
(
  // Watched pins
  input wire logic clk,
  input wire logic rst,
  input wire hds_pkg::hds_serial_in_s serial_in,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic enable_low_pin,
  input wire logic interrupt_request_line_n,
  input wire logic digital_reset_pulse,
  input wire logic play_pulse,
  input wire logic abort_stream_pulse,
  input wire logic stream_push
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] en_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Saturates, so the late check fires once per enable
  always_ff @(posedge clk)
  begin
    if (rst || enable_low_pin)
      en_cnt <= 12'h000;
    else if (en_cnt != 12'hfff)
      en_cnt <= en_cnt + 12'h001;
  end
  property p_idle;
    serial_in.chip_select_low [*4] |-> miso_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("miso driven while deselected");
  property p_drive;
    $fell(miso_oe_n) |-> !serial_in.chip_select_low && !$past(serial_in.chip_select_low);
  endproperty
  a_drive: assert property (p_drive) else $error("miso enabled without select");
  property p_launch;
    !miso_oe_n && $changed(miso) |-> !serial_in.sclk;
  endproperty
  a_launch: assert property (p_launch) else $error("miso moved while sclk high");
  property p_play_once;
    play_pulse |=> !play_pulse;
  endproperty
  a_play_once: assert property (p_play_once) else $error("play pulse too long");
  property p_push_once;
    stream_push |=> !stream_push;
  endproperty
  a_push_once: assert property (p_push_once) else $error("push pulse too long");
  property p_in_frame;
    play_pulse || abort_stream_pulse || digital_reset_pulse || stream_push
      |-> !serial_in.chip_select_low;
  endproperty
  a_in_frame: assert property (p_in_frame) else $error("strobe outside a frame");
  property p_ready_early;
    $fell(interrupt_request_line_n) |-> en_cnt >= 12'hc80;
  endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  property p_ready_late;
    en_cnt == 12'hc8a |-> !interrupt_request_line_n;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready missing");
  property p_reset;
    disable iff (1'b0) rst |=> miso_oe_n && interrupt_request_line_n;
  endproperty
  a_reset: assert property (p_reset) else $error("pins active in reset");
endmodule

bind hds_spi_slave hds_spi_slave_props u_hds_spi_slave_props (
  .clk(clk), .rst(rst), .serial_in(serial_in), .miso(miso), .miso_oe_n(miso_oe_n),
  .enable_low_pin(enable_low_pin), .interrupt_request_line_n(interrupt_request_line_n),
  .digital_reset_pulse(digital_reset_pulse), .play_pulse(play_pulse),
  .abort_stream_pulse(abort_stream_pulse), .stream_push(stream_push)
);

`default_nettype wire

// >>> dv/hds_spi_master.sv
// Behavioural mode 0 host master, 800 ns serial clock.
// Assumes callers start frames just after a clk edge.
`default_nettype none

module hds_spi_master
  import hds_pkg::*;
(
  // Serial pins
  output var hds_pkg::hds_serial_in_s serial_in,
  input wire logic miso_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial serial_in = 3'b010;
  task automatic frame(input logic [15:0] w[$], output logic [15:0] r[$]);
    logic [15:0] v;
    r = {};
    serial_in.chip_select_low = 1'b0;
    #800;
    foreach (w[k])
    begin
      for (int i = 15; i >= 0; i--)
      begin
        serial_in.mosi = w[k][i];
        #400 serial_in.sclk = 1'b1;
        v[i] = miso_line;
        #400 serial_in.sclk = 1'b0;
      end
      r.push_back(v);
    end
    // Clock stands low; released data line no longer shows its last bit
    #400 serial_in.chip_select_low = 1'b1;
    serial_in.mosi = ~serial_in.mosi;
    #800;
  endtask
endmodule

`default_nettype wire

// >>> dv/hds_spi_slave_tb_top.sv
// Self-checking bench of the serial register slave.
// Assumes the master model and the bound checker.
`default_nettype none

module hds_spi_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hds_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable_low_pin = 1'b1;
  hds_condition_s conditions = 7'h55;
  hds_serial_in_s serial_in;
  logic miso, miso_oe_n, irq_n, rst_p, play_p, abort_p, push;
  logic [11:0] stream_data;
  logic [15:0] n_play = 16'h0000, n_abort = 16'h0000, n_rst = 16'h0000, n_push = 16'h0000;
  logic [11:0] last_data = 12'h000;
  int failures = 0;
  int n_checks = 0;
  // No pull on the shared line
  wire logic miso_line = miso_oe_n ? 1'bz : miso;
  hds_spi_slave u_hds_spi_slave (.clk(clk), .rst(rst), .serial_in(serial_in), .miso(miso),
    .miso_oe_n(miso_oe_n), .enable_low_pin(enable_low_pin), .interrupt_request_line_n(irq_n),
    .conditions(conditions), .digital_reset_pulse(rst_p), .play_pulse(play_p),
    .abort_stream_pulse(abort_p), .stream_push(push), .stream_data(stream_data));
  hds_spi_master u_hds_spi_master (.serial_in(serial_in), .miso_line(miso_line));
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    n_play <= n_play + play_p;
    n_abort <= n_abort + abort_p;
    n_rst <= n_rst + rst_p;
    n_push <= n_push + push;
    if (push)
      last_data <= stream_data;
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic xfer(input logic [15:0] w[$]);
    logic [15:0] r[$];
    clks(1);
    u_hds_spi_master.frame(w, r);
  endtask
  task automatic rd(input logic [14:0] a, input logic [15:0] exp);
    logic [15:0] r[$];
    clks(1);
    u_hds_spi_master.frame('{{1'b1, a}, 16'h8005}, r);
    chk16(r[1], exp);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_regs();
    chk16({miso_oe_n, irq_n, play_p, push, stream_data}, 16'hc000);
    xfer('{16'h0007, 16'h4800});
    rd(15'h0007, 16'h4800);
    chk16(miso_oe_n, 1);
    xfer('{16'h0007, 16'h0000});
    rd(15'h0001, 16'h0055);
    conditions = 7'h2a;
    rd(15'h0005, 16'h0000);
  endtask
  task automatic t_ready();
    int k = 0;
    while (irq_n !== 1'b0 && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    chk16(k < 4000, 1);
    rd(15'h0006, 16'h4000);
    clks(4);
    chk16(irq_n, 1);
  endtask
  task automatic t_play();
    xfer('{16'h0002, 16'h0003});
    chk16(n_play, 16'h0001);
    chk16(n_abort, 16'h0001);
    rd(15'h0002, 16'h0003);
    xfer('{16'h0000, 16'h0001});
    chk16(n_rst, 1);
  endtask
  task automatic t_burst();
    xfer('{16'h0007, 16'h1234, 16'hffff, 16'hffff, 16'h0abc});
    chk16(n_push, 16'h0001);
    chk16({4'h0, last_data}, 16'h0abc);
    xfer('{16'h000a, 16'h0111, 16'h0222, 16'hf333});
    chk16(n_push, 16'h0004);
    chk16({4'h0, last_data}, 16'h0333);
    rd(15'h0007, 16'h1234);
  endtask
  task automatic t_burst_rd();
    logic [15:0] r[$];
    clks(1);
    u_hds_spi_master.frame('{16'h8007, 16'h8002, 16'h8001, 16'h8005}, r);
    chk16(r[1], 16'h1234);
    chk16(r[2], 16'h0003);
    chk16(r[3], 16'h002a);
  endtask
  task automatic t_wrap();
    // Top location itself is legal; only the word beyond it flags
    xfer('{16'h3ffe, 16'h0000, 16'h0000});
    chk16(irq_n, 1);
    xfer('{16'h3fff, 16'h0000, 16'h0000});
    chk16(irq_n, 0);
    rd(15'h0006, 16'h0800);
    xfer('{16'h8005, 16'hc000, 16'h8005});
    chk16(irq_n, 0);
    rd(15'h0006, 16'h0800);
    clks(4);
    chk16(irq_n, 1);
  endtask
  initial
  begin
    #5_000_000;
    failures++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #10 rst = 1'b0;
    enable_low_pin = 1'b0;
    clks(4);
    t_regs();
    t_ready();
    t_play();
    t_burst();
    t_burst_rd();
    t_wrap();
    stop_test();
  end
endmodule

`default_nettype wire
